// File: rtl/psr_sequencer.sv
// Purpose: momentary power failure handling and restart sequencing
// Assumes: dc link flags and drive status come from logic on clk
// Notes: run, coast-stop and interlock are pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
module psr_sequencer
    import psr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TENTH_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // settings
    input wire psr_cfg_s cfg,
    // dc link flags, synchronous
    input wire logic dc_undervoltage,
    input wire logic dc_below_continue_level,
    // drive status, synchronous
    input wire logic drive_running,
    input wire logic charge_done,
    input wire logic decel_done,
    input wire logic freq_restored,
    input wire logic alarm_reset,
    // pins from the outside
    input wire logic run_cmd_pin,
    input wire logic coast_stop_command,
    input wire logic contactor_interlock,
    // outputs to the drive
    output psr_out_s ctl,
    output psr_state_e state
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_q;
    logic [PIN_N-1:0] pin_s2_q;

    assign pin_raw[PIN_RUN] = run_cmd_pin;
    assign pin_raw[PIN_COAST] = coast_stop_command;
    assign pin_raw[PIN_INTERLOCK] = contactor_interlock;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                end
            end
        end
    endgenerate

    logic run_cmd;
    logic coast;
    logic interlock;
    assign run_cmd = pin_s2_q[PIN_RUN];
    assign coast = pin_s2_q[PIN_COAST];
    assign interlock = pin_s2_q[PIN_INTERLOCK];

    // ****************************************
    // setting decode
    // ****************************************
    logic sensor_vec;
    logic fixed_dir;
    logic wait_src;
    logic power_fail;
    logic power_ok;
    logic [OUTAGE_W-1:0] outage_limit;

    assign sensor_vec = (cfg.control_method_select == CTRL_SENSOR_VECTOR);
    assign fixed_dir = (cfg.run_command_source == SRC_FIXED_FWD) ||
        (cfg.run_command_source == SRC_FIXED_REV);
    // source 0 and terminal sources share the run-wait window
    assign wait_src = !fixed_dir ||
        (cfg.run_command_source == SRC_KEYPAD_TERM_DIR);
    // interlock active means a failure, as does dc undervoltage
    assign power_fail = dc_undervoltage || interlock;
    assign power_ok = !dc_undervoltage && !interlock && charge_done;
    // settings above 30.0 s are held at the top of the range
    assign outage_limit = (cfg.allowable_outage_time > OUTAGE_MAX) ?
        OUTAGE_MAX : cfg.allowable_outage_time;

    // ****************************************
    // timers
    // ****************************************
    logic outage_clear;
    logic wait_clear;
    logic [OUTAGE_W-1:0] outage_tenths;
    logic [OUTAGE_W-1:0] wait_tenths;
    logic outage_expired;
    logic wait_over;

    // outage counted on the control clock from the judged failure
    psr_tenth_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(OUTAGE_W)
    ) u_outage_timer (
        .clk(clk),
        .nrst(nrst),
        .clear(outage_clear),
        .tenths(outage_tenths)
    );

    psr_tenth_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(OUTAGE_W)
    ) u_wait_timer (
        .clk(clk),
        .nrst(nrst),
        .clear(wait_clear),
        .tenths(wait_tenths)
    );

    // a zero limit allows no outage at all
    assign outage_expired = (outage_tenths >= outage_limit);
    assign wait_over = (wait_tenths >= OUTAGE_W'(RUN_WAIT_TENTHS));

    // ****************************************
    // sequence state
    // ****************************************
    psr_state_e state_q;
    psr_state_e state_d;
    logic deferred_q;
    logic deferred_d;

    always_comb
    begin
        state_d = state_q;
        deferred_d = deferred_q;
        outage_clear = 1'b0;
        wait_clear = 1'b1;
        unique case (state_q)
            PSR_RUN:
            begin
                outage_clear = 1'b1;
                deferred_d = 1'b0;
                if (drive_running && power_fail)
                begin
                    unique case (cfg.restart_mode_select)
                        MODE_TRIP_NOW: state_d = PSR_TRIPPED;
                        MODE_TRIP_LATER:
                        begin
                            state_d = PSR_OUTAGE;
                            deferred_d = 1'b1;
                        end
                        MODE_DECEL_TRIP: state_d = PSR_DECEL;
                        default: state_d = PSR_OUTAGE;
                    endcase
                end
                else if (drive_running && dc_below_continue_level)
                begin
                    if (cfg.restart_mode_select == MODE_DECEL_TRIP)
                    begin
                        state_d = PSR_DECEL;
                    end
                    else if (cfg.restart_mode_select == MODE_CONTINUE)
                    begin
                        state_d = PSR_CONTINUE;
                    end
                end
            end
            PSR_DECEL:
            begin
                // alarm only once the controlled stop is over
                if (decel_done)
                begin
                    state_d = PSR_TRIPPED;
                end
            end
            PSR_CONTINUE:
            begin
                // not enough regenerated energy: drop the output and wait
                if (power_fail)
                begin
                    state_d = PSR_OUTAGE;
                end
                else if (!dc_below_continue_level)
                begin
                    state_d = PSR_RUN;
                end
            end
            PSR_OUTAGE:
            begin
                if (coast)
                begin
                    state_d = PSR_RUN;
                end
                else if (power_ok)
                begin
                    if (deferred_q)
                    begin
                        state_d = PSR_TRIPPED;
                    end
                    else if (outage_expired)
                    begin
                        // treated as a fresh power-on
                        state_d = PSR_RUN;
                    end
                    else if (!wait_src)
                    begin
                        state_d = PSR_RESTART;
                    end
                    else
                    begin
                        state_d = PSR_WAIT_RUN;
                    end
                end
            end
            PSR_WAIT_RUN:
            begin
                wait_clear = 1'b0;
                if (coast || outage_expired)
                begin
                    state_d = PSR_RUN;
                end
                else if (run_cmd)
                begin
                    // a run at the window's last tick still restarts
                    state_d = PSR_RESTART;
                end
                else if (wait_over)
                begin
                    state_d = PSR_RUN;
                end
            end
            PSR_RESTART:
            begin
                if (freq_restored || coast)
                begin
                    state_d = PSR_RUN;
                end
                else if (drive_running && power_fail)
                begin
                    state_d = PSR_OUTAGE;
                end
            end
            PSR_TRIPPED:
            begin
                if (alarm_reset)
                begin
                    state_d = PSR_RUN;
                end
            end
            default: state_d = PSR_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= PSR_RUN;
            deferred_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            deferred_q <= deferred_d;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    psr_out_s out_q;
    psr_out_s out_d;
    logic from_fail_freq;

    // open-loop modes 3 and 4 resume at the frequency held at failure
    assign from_fail_freq = !sensor_vec &&
        ((cfg.restart_mode_select == MODE_CONTINUE) ||
        (cfg.restart_mode_select == MODE_FAIL_FREQ));

    always_comb
    begin
        out_d = '0;
        out_d.output_enable = (state_d == PSR_RUN) || (state_d == PSR_DECEL) ||
            (state_d == PSR_CONTINUE) || (state_d == PSR_RESTART);
        out_d.uv_alarm = (state_d == PSR_TRIPPED);
        out_d.decel_to_stop = (state_d == PSR_DECEL);
        out_d.continue_run = (state_d == PSR_CONTINUE);
        out_d.auto_restart_active = (state_d == PSR_RESTART);
        out_d.restart_sensor_speed = (state_d == PSR_RESTART) && sensor_vec;
        out_d.restart_fail_freq = (state_d == PSR_RESTART) && from_fail_freq;
        out_d.restart_start_freq = (state_d == PSR_RESTART) && !sensor_vec &&
            (cfg.restart_mode_select == MODE_START_FREQ);
        // limiter may pull frequency down only with limiting enabled
        out_d.current_limit_follow = (state_d == PSR_RESTART) && from_fail_freq &&
            cfg.overcurrent_limit_enable;
        // leaving the outage without restart: next start is a normal one
        out_d.normal_start = (state_d == PSR_RUN) && ((state_q == PSR_OUTAGE) ||
            (state_q == PSR_WAIT_RUN));
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_q <= '0;
        end
        else
        begin
            out_q <= out_d;
        end
    end

    assign ctl = out_q;
    assign state = state_q;

endmodule : psr_sequencer
`default_nettype wire

// File: rtl/psr_pkg.sv
// Purpose: shared constants and types of the power dip restart sequencer
// Assumes: 50 MHz control clock
// Notes: times are kept in their own unit, cycle counts derive from them
package psr_pkg;

    // ****************************************
    // clock and times
    // ****************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TENTH_PER_S = 10;
    // base tick of the outage and wait timers, 0.1 s
    localparam int unsigned TENTH_CYCLES = CLK_HZ / TENTH_PER_S;
    localparam int unsigned RUN_WAIT_S = 2;
    localparam logic [4:0] RUN_WAIT_TENTHS = 5'(RUN_WAIT_S * TENTH_PER_S);
    // allowable outage time, in tenths of a second: 0.0 .. 30.0 s
    localparam int unsigned OUTAGE_W = 9;
    localparam logic [OUTAGE_W-1:0] OUTAGE_MAX = 9'h12C;

    // ****************************************
    // setting codes
    // ****************************************
    localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
    localparam logic [2:0] MODE_TRIP_LATER = 3'h1;
    localparam logic [2:0] MODE_DECEL_TRIP = 3'h2;
    localparam logic [2:0] MODE_CONTINUE = 3'h3;
    localparam logic [2:0] MODE_FAIL_FREQ = 3'h4;
    localparam logic [2:0] MODE_START_FREQ = 3'h5;
    localparam logic [2:0] CTRL_SENSOR_VECTOR = 3'h6;
    localparam logic [1:0] SRC_KEYPAD_TERM_DIR = 2'h0;
    localparam logic [1:0] SRC_FIXED_FWD = 2'h2;
    localparam logic [1:0] SRC_FIXED_REV = 2'h3;

    // ****************************************
    // pin indices and types
    // ****************************************
    localparam int unsigned PIN_N = 3;
    localparam int unsigned PIN_RUN = 0;
    localparam int unsigned PIN_COAST = 1;
    localparam int unsigned PIN_INTERLOCK = 2;

    typedef enum logic [2:0] {
        PSR_RUN = 3'b000,
        PSR_DECEL = 3'b001,
        PSR_CONTINUE = 3'b010,
        PSR_OUTAGE = 3'b011,
        PSR_WAIT_RUN = 3'b100,
        PSR_RESTART = 3'b101,
        PSR_TRIPPED = 3'b110
    } psr_state_e;

    typedef struct packed {
        logic [2:0] restart_mode_select;
        logic [2:0] control_method_select;
        logic [1:0] run_command_source;
        logic [OUTAGE_W-1:0] allowable_outage_time;
        logic overcurrent_limit_enable;
    } psr_cfg_s;

    typedef struct packed {
        logic output_enable;
        logic uv_alarm;
        logic decel_to_stop;
        logic continue_run;
        logic auto_restart_active;
        logic restart_fail_freq;
        logic restart_start_freq;
        logic restart_sensor_speed;
        logic current_limit_follow;
        logic normal_start;
    } psr_out_s;

endpackage : psr_pkg

// File: rtl/psr_tenth_timer.sv
// Purpose: tick generator and saturating tenth-second counter
// Assumes: clear is synchronous and has priority over counting
// Notes: count saturates at its top value instead of wrapping
`timescale 1ns/1ps
`default_nettype none
module psr_tenth_timer
    import psr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TENTH_CYCLES,
    parameter int unsigned CNT_W = OUTAGE_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic clear,
    // count of whole tenths since clear
    output logic [CNT_W-1:0] tenths
);

    // ****************************************
    // prescaler and counter
    // ****************************************
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
    logic [31:0] pre_q;
    logic [31:0] pre_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb
    begin
        pre_d = pre_q + 32'h0000_0001;
        cnt_d = cnt_q;
        if (clear)
        begin
            pre_d = '0;
            cnt_d = '0;
        end
        else if (pre_q >= TICK_LAST)
        begin
            pre_d = '0;
            // saturate so a long outage never looks short again
            if (cnt_q != {CNT_W{1'b1}})
            begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign tenths = cnt_q;

endmodule : psr_tenth_timer
`default_nettype wire

// File: test/psr_sequencer_props.sv
// Purpose: assertions on the ports of the restart sequencer
// Assumes: one clock domain, asynchronous active low reset
// Notes: wait bound allows one tick of slack for the timer phase
`timescale 1ns/1ps
`default_nettype none
module psr_sequencer_props
    import psr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TENTH_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sequencer inputs
    input wire psr_cfg_s cfg,
    input wire logic dc_undervoltage,
    input wire logic dc_below_continue_level,
    input wire logic drive_running,
    input wire logic charge_done,
    input wire logic decel_done,
    input wire logic freq_restored,
    input wire logic alarm_reset,
    input wire logic run_cmd_pin,
    input wire logic coast_stop_command,
    input wire logic contactor_interlock,
    // sequencer outputs
    input wire psr_out_s ctl,
    input wire psr_state_e state
);
    // ****************************************
    // window counter and properties
    // ****************************************
    localparam int unsigned WIN_MAX = 21 * TICK_CYCLES + 2;
    int unsigned win_d;
    int unsigned win_q;
    always_comb win_d = (state == PSR_WAIT_RUN) ? win_q + 1 : 0;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            win_q <= 0;
        else
            win_q <= win_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_run;
        state == PSR_RUN && drive_running;
    endsequence
    sequence s_tripped;
        state == PSR_TRIPPED && ctl.uv_alarm && !ctl.output_enable;
    endsequence
    AST_TRIP_NOW: assert property ((s_run ##0 (dc_undervoltage && cfg.restart_mode_select == MODE_TRIP_NOW)) |=> s_tripped)
        else $error("immediate trip missed");
    AST_TRIP_LATER: assert property ((s_run ##0 (dc_undervoltage && cfg.restart_mode_select == MODE_TRIP_LATER)) |=> (state == PSR_OUTAGE && !ctl.uv_alarm && !ctl.output_enable))
        else $error("deferred trip alarmed or kept output");
    AST_DECEL_START: assert property ((s_run ##0 (dc_below_continue_level && cfg.restart_mode_select == MODE_DECEL_TRIP)) |=> (state == PSR_DECEL && ctl.decel_to_stop && !ctl.uv_alarm))
        else $error("decel not started");
    AST_DECEL_END: assert property ((state == PSR_DECEL && decel_done) |=> s_tripped)
        else $error("no alarm after decel");
    AST_CONTINUE: assert property ((s_run ##0 (dc_below_continue_level && !dc_undervoltage && cfg.restart_mode_select == MODE_CONTINUE)) |=> (state == PSR_CONTINUE && ctl.continue_run))
        else $error("continue run not entered");
    AST_OFF_IN_OUTAGE: assert property ((state == PSR_OUTAGE || state == PSR_WAIT_RUN) |-> !ctl.output_enable)
        else $error("output on during outage");
    AST_WAIT_BOUND: assert property (win_q <= WIN_MAX)
        else $error("run wait too long");
    AST_FLAG_HELD: assert property ((state == PSR_RESTART) |-> ctl.auto_restart_active)
        else $error("restart flag low in restart");
    AST_RESTART_END: assert property ((state == PSR_RESTART && freq_restored) |=> (state == PSR_RUN && !ctl.auto_restart_active))
        else $error("restart did not end");
    AST_PULSE: assert property (ctl.normal_start |-> (state == PSR_RUN) ##1 !ctl.normal_start)
        else $error("normal start not a pulse");
    AST_LIMIT: assert property ((state == PSR_RESTART && $stable(cfg) && cfg.restart_mode_select == MODE_FAIL_FREQ && cfg.control_method_select != CTRL_SENSOR_VECTOR) |-> ctl.current_limit_follow == cfg.overcurrent_limit_enable)
        else $error("limiter follow wrong");
endmodule : psr_sequencer_props

bind psr_sequencer psr_sequencer_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk(clk), .nrst(nrst), .cfg(cfg), .dc_undervoltage(dc_undervoltage),
    .dc_below_continue_level(dc_below_continue_level), .drive_running(drive_running),
    .charge_done(charge_done), .decel_done(decel_done), .freq_restored(freq_restored),
    .alarm_reset(alarm_reset), .run_cmd_pin(run_cmd_pin),
    .coast_stop_command(coast_stop_command), .contactor_interlock(contactor_interlock),
    .ctl(ctl), .state(state));
`default_nettype wire

// File: test/psr_relay_model.sv
// Purpose: run relay circuit and output contactor outside the drive
// Assumes: relay supply follows the mains
// Notes: without a latch the command returns only after the relay re-powers
`timescale 1ns/1ps
`default_nettype none
module psr_relay_model
    import psr_pkg::*;
#(
    parameter int unsigned RET_CYCLES = 40
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // plant
    input wire logic mains,
    input wire logic run_req,
    input wire logic latch,
    input wire logic fitted,
    // pins to the drive
    output logic run_cmd_pin,
    output logic contactor_interlock
);
    int unsigned up_q;
    logic held_q;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            up_q <= 0;
            held_q <= 1'h0;
        end
        else
        begin
            up_q <= !mains ? 0 : ((up_q < RET_CYCLES) ? up_q + 1 : up_q);
            held_q <= latch & run_req;
        end
    // command sags with the relay supply unless latched, returns within the window
    assign run_cmd_pin = run_req && (held_q || (mains && up_q >= RET_CYCLES));
    // aux contact opens with the coil when the mains goes
    assign contactor_interlock = fitted && !mains;
endmodule : psr_relay_model
`default_nettype wire

// File: test/psr_sequencer_test.sv
// Purpose: self-checking bench of the restart sequencer
// Assumes: short tick so the 2 s window is 200 cycles
// Notes: dc flags and the coast pin are driven directly, run and interlock pins come from the relay model
`timescale 1ns/1ps
`default_nettype none
module psr_sequencer_test;
    import psr_pkg::*;
    localparam int unsigned TICK = 10;
    logic clk = 1'h0, nrst = 1'h0, dc_uv = 1'h0, dc_low = 1'h0, running = 1'h0, charge = 1'h1;
    logic dec_done = 1'h0, freq_ok = 1'h0, alarm_rst = 1'h0, coast = 1'h0;
    logic mains = 1'h1, run_req = 1'h0, latch = 1'h0, fitted = 1'h0;
    wire logic run_pin, ilk_pin;
    psr_cfg_s cfg = '0;
    psr_out_s ctl;
    psr_state_e state;
    int mismatches = 0, n_compared = 0, cycles = 0;
    always #10 clk = ~clk;
    psr_sequencer #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .nrst(nrst), .cfg(cfg),
        .dc_undervoltage(dc_uv), .dc_below_continue_level(dc_low), .drive_running(running),
        .charge_done(charge), .decel_done(dec_done), .freq_restored(freq_ok),
        .alarm_reset(alarm_rst), .run_cmd_pin(run_pin), .coast_stop_command(coast),
        .contactor_interlock(ilk_pin), .ctl(ctl), .state(state));
    psr_relay_model u_relay (.clk(clk), .nrst(nrst), .mains(mains), .run_req(run_req),
        .latch(latch), .fitted(fitted), .run_cmd_pin(run_pin), .contactor_interlock(ilk_pin));
    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_st(input psr_state_e st, input int lim);
        for (int i = 0; i < lim && state !== st; i++)
            step(1);
        chk("state", state, st);
    endtask : wait_st
    task automatic wait_pulse(input int lim);
        for (int i = 0; i < lim && ctl.normal_start !== 1'h1; i++)
            step(1);
        chk("normal_start", ctl.normal_start, 1);
    endtask : wait_pulse
    task automatic setup(input logic [2:0] m, input logic [1:0] s = 2'h0,
        input logic [2:0] c = 3'h0, input logic [8:0] lim = OUTAGE_MAX, input logic ocl = 1'h1);
        cfg = '{m, c, s, lim, ocl};
    endtask : setup
    task automatic down();
        mains = 1'h0;
        dc_uv = 1'h1;
        charge = 1'h0;
    endtask : down
    task automatic up();
        mains = 1'h1;
        dc_uv = 1'h0;
        charge = 1'h1;
    endtask : up
    task automatic clear_trip();
        alarm_rst = 1'h1;
        step(1);
        alarm_rst = 1'h0;
        chk("output_enable", ctl.output_enable, 1);
    endtask : clear_trip
    task automatic restored();
        freq_ok = 1'h1;
        step(1);
        freq_ok = 1'h0;
        chk("state", state, PSR_RUN);
        chk("auto_restart_active", ctl.auto_restart_active, 0);
    endtask : restored
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_trip_now();
        setup(MODE_TRIP_NOW);
        running = 1'h0;
        dc_uv = 1'h1;
        step(3);
        chk("state", state, PSR_RUN);
        running = 1'h1;
        step(1);
        dc_uv = 1'h0;
        chk("state", state, PSR_TRIPPED);
        chk("uv_alarm", ctl.uv_alarm, 1);
        chk("output_enable", ctl.output_enable, 0);
        clear_trip();
    endtask : t_trip_now
    task automatic t_trip_later();
        setup(MODE_TRIP_LATER);
        down();
        step(3);
        chk("state", state, PSR_OUTAGE);
        chk("uv_alarm", ctl.uv_alarm, 0);
        up();
        wait_st(PSR_TRIPPED, 3);
        chk("uv_alarm", ctl.uv_alarm, 1);
        clear_trip();
    endtask : t_trip_later
    task automatic t_decel();
        setup(MODE_DECEL_TRIP);
        dc_low = 1'h1;
        step(1);
        chk("decel_to_stop", ctl.decel_to_stop, 1);
        step(4);
        chk("uv_alarm", ctl.uv_alarm, 0);
        dec_done = 1'h1;
        step(1);
        dec_done = 1'h0;
        dc_low = 1'h0;
        chk("state", state, PSR_TRIPPED);
        clear_trip();
        setup(MODE_CONTINUE, 2'h0, CTRL_SENSOR_VECTOR);
        dc_low = 1'h1;
        step(1);
        dc_low = 1'h0;
        chk("continue_run", ctl.continue_run, 1);
        wait_st(PSR_RUN, 4);
    endtask : t_decel
    task automatic t_restart(input logic [2:0] m, input logic [2:0] c, input logic [2:0] flags);
        setup(m, SRC_KEYPAD_TERM_DIR, c);
        run_req = 1'h1;
        down();
        step(1);
        chk("state", state, PSR_OUTAGE);
        chk("output_enable", ctl.output_enable, 0);
        step(10);
        up();
        step(20);
        chk("state", state, PSR_WAIT_RUN);
        wait_st(PSR_RESTART, 60);
        chk("flags", {ctl.restart_fail_freq, ctl.restart_start_freq, ctl.restart_sensor_speed}, flags);
        if (flags == 3'h4)
            chk("current_limit_follow", ctl.current_limit_follow, 1);
        step(5);
        run_req = 1'h0;
        chk("auto_restart_active", ctl.auto_restart_active, 1);
        restored();
    endtask : t_restart
    task automatic t_no_run();
        setup(MODE_FAIL_FREQ);
        down();
        step(10);
        up();
        step(1);
        step(TICK * 19);
        chk("state", state, PSR_WAIT_RUN);
        wait_pulse(TICK * 3);
        chk("state", state, PSR_RUN);
        run_req = 1'h1;
        step(50);
        chk("state", state, PSR_RUN);
        run_req = 1'h0;
    endtask : t_no_run
    task automatic t_fixed(input logic [1:0] s, input logic ocl);
        setup(MODE_FAIL_FREQ, s, 3'h0, OUTAGE_MAX, ocl);
        down();
        step(5);
        up();
        wait_st(PSR_RESTART, 4);
        chk("current_limit_follow", ctl.current_limit_follow, ocl);
        restored();
    endtask : t_fixed
    task automatic t_coast();
        setup(MODE_FAIL_FREQ);
        down();
        step(3);
        running = 1'h0;
        coast = 1'h1;
        wait_st(PSR_RUN, 6);
        chk("normal_start", ctl.normal_start, 1);
        coast = 1'h0;
        up();
        run_req = 1'h1;
        step(60);
        chk("state", state, PSR_RUN);
        run_req = 1'h0;
        running = 1'h1;
    endtask : t_coast
    task automatic t_interlock();
        setup(MODE_FAIL_FREQ);
        fitted = 1'h1;
        latch = 1'h1;
        run_req = 1'h1;
        mains = 1'h0;
        wait_st(PSR_OUTAGE, 6);
        step(5);
        mains = 1'h1;
        wait_st(PSR_RESTART, 10);
        fitted = 1'h0;
        run_req = 1'h0;
        restored();
        setup(MODE_FAIL_FREQ, 2'h0, 3'h0, 9'h005);
        run_req = 1'h1;
        step(2);
        down();
        step(TICK * 8);
        up();
        wait_pulse(6);
        chk("state", state, PSR_RUN);
        latch = 1'h0;
        run_req = 1'h0;
        down();
        step(TICK * 2);
        up();
        wait_st(PSR_WAIT_RUN, 3);
        wait_pulse(TICK * 4);
        chk("state", state, PSR_RUN);
    endtask : t_interlock
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        #2;
        chk("ctl", ctl, 0);
        nrst = 1'h1;
        step(1);
        running = 1'h1;
        chk("output_enable", ctl.output_enable, 1);
        t_trip_now();
        t_trip_later();
        t_decel();
        t_restart(MODE_FAIL_FREQ, 3'h0, 3'h4);
        t_restart(MODE_START_FREQ, 3'h0, 3'h2);
        t_restart(MODE_FAIL_FREQ, CTRL_SENSOR_VECTOR, 3'h1);
        t_no_run();
        t_fixed(SRC_FIXED_FWD, 1'h1);
        t_fixed(SRC_FIXED_REV, 1'h0);
        t_coast();
        t_interlock();
        give_verdict();
    end
endmodule : psr_sequencer_test
`default_nettype wire
